// file: alarm_latch_map.svh
`ifndef ALARM_LATCH_MAP_SVH
`define ALARM_LATCH_MAP_SVH
// number of alarms in the block
`define ALM_COUNT 6
// width of the per-alarm delay setting, in bits
`define ALM_DLY_W 16
// message cycling dwell, in sample ticks
`define ALM_MSG_DWELL 16'h000a
// reset values
`define ALM_DLY_ZERO 16'h0000
`define ALM_IDX_ZERO 3'h0
// latching mode codes
`define ALM_LATCH_NONE 2'h0
`define ALM_LATCH_AUTO 2'h1
`define ALM_LATCH_MANUAL 2'h2
`define ALM_LATCH_EVENT 2'h3
`endif

// file: alarm_latch_pkg.sv
`default_nettype none
`include "alarm_latch_map.svh"
package alarm_latch_pkg;
  typedef enum logic [1:0] {
    LATCH_NONE = `ALM_LATCH_NONE,
    LATCH_AUTO = `ALM_LATCH_AUTO,
    LATCH_MANUAL = `ALM_LATCH_MANUAL,
    LATCH_EVENT = `ALM_LATCH_EVENT
  } latch_mode_e;
  // per-alarm state along the usual path: idle -> delaying -> active -> (acked) -> idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DELAY = 3'h1,
    ST_ACTIVE = 3'h3,
    ST_ACKED = 3'h2,
    ST_WAIT_ACK = 3'h6
  } alarm_state_e;
  typedef struct packed {
    alarm_state_e st;
    logic blocked;
    logic [`ALM_DLY_W-1:0] dly_cnt;
    logic out;
    logic unacked;
  } alarm_s;
endpackage : alarm_latch_pkg
`default_nettype wire

// file: alarm_panel_model.sv
`default_nettype none
module alarm_panel_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  input wire logic [1:0] i_sel,
  output logic o_tick,
  output logic [3:0] o_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q;
  logic [3:0] hold_q;
  assign o_tick = div_q == 2'h3;
  // one source held across two ticks
  assign o_ack = (hold_q != 4'h0) ? 4'h1 << i_sel : 4'h0;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= 2'h0;
      hold_q <= 4'h0;
    end else begin
      div_q <= div_q + 2'h1;
      hold_q <= i_go ? 4'h8 : hold_q - 4'(hold_q != 4'h0);
    end
  end
endmodule : alarm_panel_model
`default_nettype wire

// file: process_alarm_latch_block.sv
`default_nettype none
`include "alarm_latch_map.svh"
module process_alarm_latch_block
  import alarm_latch_pkg::*;
#(
  parameter int N = `ALM_COUNT,
  parameter int DW = `ALM_DLY_W
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_SAMPLE_TICK,
  input wire logic [N-1:0] I_COND,
  input wire logic [N-1:0] I_INHIBIT,
  input wire logic [N-1:0] I_STANDBY_INH_EN,
  input wire logic I_STANDBY,
  input wire logic I_CONFIG_MODE,
  input wire logic [N-1:0] I_BLOCK_EN,
  input wire logic [N-1:0] I_IS_DEVIATION,
  input wire logic I_REF_CHANGED,
  input wire logic [2*N-1:0] I_LATCH_MODE,
  input wire logic [N*DW-1:0] I_DELAY,
  input wire logic [N-1:0] I_OUT_ENERGISE_IN_ALARM,
  input wire logic I_FRONT_KEY_ACK,
  input wire logic I_FUNC_KEY_ACK,
  input wire logic I_DIGITAL_IN_ACK,
  input wire logic I_GLOBAL_ACK,
  input wire logic [N-1:0] I_ACK_PARAM_SET,
  output logic [N-1:0] O_ACK_PARAM,
  output logic [N-1:0] O_ACTIVE,
  output logic [N-1:0] O_OUTPUT_DRIVE,
  output logic O_BEACON_ON,
  output logic O_BEACON_FLASH,
  output logic O_PV_RED,
  output logic O_MSG_VALID,
  output logic [2:0] O_MSG_ALARM_NUM
);

  typedef struct packed {
    alarm_s [N-1:0] alm;
    logic [N-1:0] ack_param;
    logic cfg_prev;
    logic [2:0] msg_idx;
    logic [DW-1:0] msg_cnt;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic rearm_event;
  logic any_ack;
  logic [N-1:0] ack_hit;
  logic [N-1:0] inhibited;
  logic [N-1:0] shown;
  logic [N-1:0] unacked;

  // config exit is one re-arm moment; reset, inhibit and a reference change on deviation alarms also arm blocking
  assign rearm_event = s_q.cfg_prev & ~I_CONFIG_MODE;
  assign any_ack = I_FRONT_KEY_ACK | I_FUNC_KEY_ACK | I_DIGITAL_IN_ACK | I_GLOBAL_ACK;

  always_comb begin
    logic [1:0] mode;
    logic cond;
    logic [DW-1:0] dly;
    logic [2:0] nxt;
    mode = `ALM_LATCH_NONE;
    cond = 1'b0;
    dly = `ALM_DLY_ZERO;
    nxt = `ALM_IDX_ZERO;
    s_d = s_q;
    for (int i = 0; i < N; i++) begin
      mode = I_LATCH_MODE[2*i +: 2];
      dly = I_DELAY[DW*i +: DW];
      inhibited[i] = I_INHIBIT[i] | (I_STANDBY_INH_EN[i] & (I_STANDBY | I_CONFIG_MODE));
      ack_hit[i] = any_ack | s_q.ack_param[i];
      // parameter write latches until a tick accepts it
      if (I_ACK_PARAM_SET[i]) begin
        s_d.ack_param[i] = 1'b1;
      end
      if (I_SAMPLE_TICK) begin
        s_d.ack_param[i] = I_ACK_PARAM_SET[i];
        cond = I_COND[i] & ~inhibited[i];
        // blocking released once the value is in the working state
        if (!I_COND[i]) begin
          s_d.alm[i].blocked = 1'b0;
        end else if (s_q.alm[i].blocked && I_BLOCK_EN[i]) begin
          cond = 1'b0;
        end
        if (inhibited[i] && I_BLOCK_EN[i]) begin
          s_d.alm[i].blocked = 1'b1;
        end
        if (I_REF_CHANGED && I_IS_DEVIATION[i] && I_BLOCK_EN[i]) begin
          s_d.alm[i].blocked = 1'b1;
        end
        // config exit re-arm by latch mode
        if (rearm_event && I_BLOCK_EN[i]) begin
          if (mode == `ALM_LATCH_NONE || mode == `ALM_LATCH_EVENT ||
              (mode == `ALM_LATCH_AUTO && !s_q.alm[i].unacked)) begin
            s_d.alm[i].blocked = 1'b1;
          end
        end
        unique case (s_q.alm[i].st)
          ST_IDLE: begin
            if (cond) begin
              s_d.alm[i].st = ST_DELAY;
              s_d.alm[i].dly_cnt = `ALM_DLY_ZERO;
            end
          end
          ST_DELAY: begin
            // delay restarts if the condition drops
            if (!cond) begin
              s_d.alm[i].st = ST_IDLE;
              s_d.alm[i].dly_cnt = `ALM_DLY_ZERO;
            end else if (s_q.alm[i].dly_cnt >= dly) begin
              s_d.alm[i].st = ST_ACTIVE;
              s_d.alm[i].unacked = (mode != `ALM_LATCH_EVENT);
            end else begin
              s_d.alm[i].dly_cnt = s_q.alm[i].dly_cnt + 1'b1;
            end
          end
          ST_ACTIVE: begin
            if (!cond) begin
              // non-latching and event clear by themselves
              if (mode == `ALM_LATCH_NONE || mode == `ALM_LATCH_EVENT) begin
                s_d.alm[i].st = ST_IDLE;
                s_d.alm[i].unacked = 1'b0;
              end else begin
                s_d.alm[i].st = ST_WAIT_ACK;
              end
            end else if (ack_hit[i]) begin
              // ack while active: steady beacon except in manual latch, output kept
              // manual latch ignores an ack while the condition persists
              if (mode != `ALM_LATCH_MANUAL) begin
                s_d.alm[i].unacked = 1'b0;
              end
              // auto accepts the early ack, manual ignores it
              if (mode == `ALM_LATCH_AUTO) begin
                s_d.alm[i].st = ST_ACKED;
              end
            end
          end
          ST_ACKED: begin
            if (!cond) begin
              s_d.alm[i].st = ST_IDLE;
            end
          end
          ST_WAIT_ACK: begin
            // ack after condition cleared releases the latch
            if (cond) begin
              s_d.alm[i].st = ST_ACTIVE;
            end else if (ack_hit[i]) begin
              s_d.alm[i].st = ST_IDLE;
              s_d.alm[i].unacked = 1'b0;
            end
          end
          default: begin
            s_d.alm[i].st = ST_IDLE;
          end
        endcase
        // default polarity de-energises the output in alarm
        s_d.alm[i].out = ((s_d.alm[i].st == ST_ACTIVE) || (s_d.alm[i].st == ST_ACKED) ||
                          (s_d.alm[i].st == ST_WAIT_ACK)) ~^ I_OUT_ENERGISE_IN_ALARM[i];
      end
      shown[i] = (mode != `ALM_LATCH_EVENT) && (s_q.alm[i].st != ST_IDLE) &&
                 (s_q.alm[i].st != ST_DELAY);
      unacked[i] = shown[i] & s_q.alm[i].unacked;
    end
    if (I_SAMPLE_TICK) begin
      // config mode tracked per tick so an exit between ticks still re-arms
      s_d.cfg_prev = I_CONFIG_MODE;
      if (!shown[s_q.msg_idx] || s_q.msg_cnt >= DW'(`ALM_MSG_DWELL)) begin
        s_d.msg_cnt = `ALM_DLY_ZERO;
        nxt = s_q.msg_idx;
        for (int k = 1; k <= N; k++) begin
          if (shown[(int'(s_q.msg_idx) + k) % N] && nxt == s_q.msg_idx) begin
            nxt = 3'((int'(s_q.msg_idx) + k) % N);
          end
        end
        s_d.msg_idx = nxt;
      end else begin
        s_d.msg_cnt = s_q.msg_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      // power cycle arms blocking in every latch mode; only I_BLOCK_EN gates it
      s_q <= '0;
      for (int i = 0; i < N; i++) begin
        s_q.alm[i].blocked <= 1'b1;
        s_q.alm[i].out <= 1'b1;
      end
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      O_ACTIVE[i] = (s_q.alm[i].st == ST_ACTIVE) || (s_q.alm[i].st == ST_ACKED) ||
                    (s_q.alm[i].st == ST_WAIT_ACK);
      O_OUTPUT_DRIVE[i] = s_q.alm[i].out;
    end
  end

  assign O_ACK_PARAM = s_q.ack_param;
  // beacon holds while anything shown remains
  assign O_BEACON_ON = |shown;
  // flashing and red value for unacked alarms
  assign O_BEACON_FLASH = |unacked;
  assign O_PV_RED = |unacked;
  assign O_MSG_VALID = |shown;
  assign O_MSG_ALARM_NUM = s_q.msg_idx;

endmodule : process_alarm_latch_block
`default_nettype wire

// file: process_alarm_latch_block_props.sv
`default_nettype none
module alarm_latch_props
  import alarm_latch_pkg::*;
#(
  parameter int N = 6
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_SAMPLE_TICK,
  input wire logic [N-1:0] I_INHIBIT,
  input wire logic [N-1:0] I_STANDBY_INH_EN,
  input wire logic I_STANDBY,
  input wire logic I_CONFIG_MODE,
  input wire logic [2*N-1:0] I_LATCH_MODE,
  input wire logic [N-1:0] I_ACK_PARAM_SET,
  input wire logic [N-1:0] O_ACK_PARAM,
  input wire logic [N-1:0] O_ACTIVE,
  input wire logic O_BEACON_ON,
  input wire logic O_BEACON_FLASH,
  input wire logic O_MSG_VALID,
  input wire logic [2:0] O_MSG_ALARM_NUM
);
  logic [N-1:0] ev;
  logic [N-1:0] man;
  logic [N-1:0] sb;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ev[i] = I_LATCH_MODE[2*i+:2] == LATCH_EVENT;
      man[i] = I_LATCH_MODE[2*i+:2] == LATCH_MANUAL;
    end
  end
  assign sb = I_STANDBY_INH_EN & {N{I_STANDBY | I_CONFIG_MODE}};
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  AST_RESET_IDLE: assert property ($rose(I_NRST) |-> O_ACTIVE == '0 && !O_BEACON_ON)
    else $error("alarm state not idle after reset");
  AST_NO_TICK_HOLD: assert property (!$past(I_SAMPLE_TICK) |-> $stable(O_ACTIVE))
    else $error("alarm state moved without a sample tick");
  AST_INHIBIT_HOLDS: assert property ((O_ACTIVE & ~$past(O_ACTIVE) & $past(I_INHIBIT)) == '0)
    else $error("inhibited alarm became active");
  AST_STANDBY_HOLDS: assert property ((O_ACTIVE & ~$past(O_ACTIVE) & $past(sb)) == '0)
    else $error("alarm became active in standby");
  AST_BEACON_LIT: assert property (|(O_ACTIVE & ~ev) |-> O_BEACON_ON)
    else $error("beacon off while a displayed alarm is active");
  AST_FLASH_LIT: assert property (O_BEACON_FLASH |-> O_BEACON_ON)
    else $error("beacon flashing but not lit");
  AST_ACK_SET: assert property (|I_ACK_PARAM_SET |=>
    (O_ACK_PARAM & $past(I_ACK_PARAM_SET)) == $past(I_ACK_PARAM_SET))
    else $error("ack parameter write lost");
  AST_ACK_CLEAR: assert property (I_SAMPLE_TICK |=>
    (O_ACK_PARAM & ~man & ~$past(I_ACK_PARAM_SET)) == '0)
    else $error("ack parameter did not clear on tick");
  AST_MSG_RANGE: assert property (O_MSG_VALID |-> O_MSG_ALARM_NUM < 3'(N))
    else $error("message index out of range");
endmodule : alarm_latch_props
bind process_alarm_latch_block alarm_latch_props #(.N(N)) u_props (.*);
`default_nettype wire

// file: tb_process_alarm_latch_block.sv
`default_nettype none
module tb_process_alarm_latch_block;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, tick, go = 1'b0, cfg = 1'b0, bon, bfl, red, mv;
  logic [1:0] sel = 2'h0;
  logic [3:0] ak;
  logic [5:0] c = 6'h00, inh = 6'h00, sbe = 6'h00, aps = 6'h00, en, act, drv, apo;
  logic [2:0] mn;
  logic [95:0] dly;
  logic [15:0] q[$];
  int err_total = 0, n_tests = 0, seed = 32'h91fa;
  process_alarm_latch_block DUT (.I_REF_CLK(clk), .I_NRST(nrst), .I_SAMPLE_TICK(tick),
    .I_COND(c), .I_INHIBIT(inh), .I_STANDBY_INH_EN(sbe), .I_STANDBY(1'b0),
    .I_CONFIG_MODE(cfg), .I_BLOCK_EN(6'h20), .I_IS_DEVIATION(6'h00), .I_REF_CHANGED(1'b0),
    .I_LATCH_MODE(12'h0e4), .I_DELAY(dly), .I_OUT_ENERGISE_IN_ALARM(en),
    .I_FRONT_KEY_ACK(ak[0]), .I_FUNC_KEY_ACK(ak[1]), .I_DIGITAL_IN_ACK(ak[2]),
    .I_GLOBAL_ACK(ak[3]), .I_ACK_PARAM_SET(aps), .O_ACK_PARAM(apo), .O_ACTIVE(act),
    .O_OUTPUT_DRIVE(drv), .O_BEACON_ON(bon), .O_BEACON_FLASH(bfl), .O_PV_RED(red),
    .O_MSG_VALID(mv), .O_MSG_ALARM_NUM(mn));
  alarm_panel_model u_panel (.i_clk(clk), .i_nrst(nrst), .i_go(go), .i_sel(sel),
    .o_tick(tick), .o_ack(ak));
  initial forever #50 clk = ~clk;
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED status exp %h seen %h", e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk iff tick);
  endtask : wt
  task automatic setc(input logic [5:0] v, input int n);
    @(posedge clk);
    c <= v;
    wt(n);
  endtask : setc
  // expected status: active, drive from polarity, beacon on/flash and red
  task automatic ex(input logic [5:0] a, input logic [2:0] b);
    // message shown whenever the beacon is lit
    q.push_back({a, a ~^ en, b, b[2]});
  endtask : ex
  task automatic ack_by(input logic [1:0] s);
    @(posedge clk);
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wt(3);
  endtask : ack_by
  always @(negedge clk) begin
    if (q.size() > 0) chk({act, drv, bon, bfl, red, mv}, q.pop_front());
  end
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
  initial begin
    en <= 6'($random(seed));
    for (int i = 0; i < 6; i++) dly[16*i+:16] <= 16'($random(seed) & 3);
    // long delay on alarm 0 so a short condition never latches
    dly[15:0] <= 16'h0006;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    wt(2);
    ex(6'h00, 3'h0);
    @(posedge clk);
    inh <= 6'h10;
    setc(6'h3f, 10);
    ex(6'h2f, 3'h7);
    ack_by(2'h0);
    ex(6'h2f, 3'h7);
    @(posedge clk);
    inh <= 6'h00;
    setc(6'h00, 10);
    ex(6'h04, 3'h7);
    @(posedge clk);
    aps <= 6'h04;
    @(posedge clk);
    aps <= 6'h00;
    wt(3);
    ex(6'h00, 3'h0);
    setc(6'h21, 10);
    ex(6'h21, 3'h7);
    ack_by(2'h3);
    ex(6'h21, 3'h4);
    setc(6'h00, 3);
    @(posedge clk);
    inh <= 6'h20;
    wt(3);
    @(posedge clk);
    inh <= 6'h00;
    setc(6'h20, 10);
    ex(6'h00, 3'h0);
    setc(6'h00, 3);
    setc(6'h20, 10);
    ex(6'h20, 3'h7);
    setc(6'h00, 3);
    @(posedge clk);
    sbe <= 6'h10;
    cfg <= 1'b1;
    setc(6'h10, 10);
    ex(6'h00, 3'h0);
    @(posedge clk);
    cfg <= 1'b0;
    wt(10);
    ex(6'h10, 3'h7);
    @(negedge clk) chk(16'(mn), 16'h0004);
    setc(6'h01, 3);
    setc(6'h00, 10);
    ex(6'h00, 3'h0);
    for (int k = 0; k < 3; k++) begin
      setc(6'h02, 10);
      setc(6'h00, 3);
      ex(6'h02, 3'h7);
      ack_by(2'(k));
      ex(6'h00, 3'h0);
    end
    @(posedge clk);
    finish_test();
  end
endmodule : tb_process_alarm_latch_block
`default_nettype wire
